// *** core/haptic_loop_pkg.sv ***
`default_nettype none
package haptic_loop_pkg;
  // ***************************************************************
  // Register map and field layout.
  // ***************************************************************
  localparam logic [7:0] REG_LOOP_DRIVE_CFG   = 8'h1b;
  localparam logic [7:0] REG_INPUT_TIMING_CFG = 8'h1c;
  localparam logic [7:0] REG_LOOP_STATUS      = 8'h1d;
  localparam int BIT_OVERDRIVE_BOOST = 7;
  localparam int BIT_RESERVED_CFG1   = 6;
  localparam int BIT_CM_DRIVE        = 5;
  localparam int BIT_SIGNED_INPUT    = 7;
  localparam int BIT_BRAKE_GAIN_RED  = 6;
  localparam logic [7:0] CFG1_RESET     = 8'h93;
  localparam logic [7:0] CFG2_RESET     = 8'hf5;
  localparam logic [7:0] CFG1_WMASK     = 8'hbf;
  localparam int DRIVE_W = 5;
  localparam int AMP_W   = 8;
  // ***************************************************************
  // Timing, in microseconds, and the derived cycle counts at 10 MHz.
  // ***************************************************************
  localparam int CLK_HZ            = 10_000_000;
  localparam int LRA_STEP_US       = 100;
  localparam int LRA_BASE_US       = 500;
  localparam int ERM_STEP_US       = 200;
  localparam int ERM_BASE_US       = 1000;
  localparam int CYC_PER_US        = CLK_HZ / 1_000_000;
  localparam int LRA_STEP_CYC      = LRA_STEP_US * CYC_PER_US;
  localparam int LRA_BASE_CYC      = LRA_BASE_US * CYC_PER_US;
  localparam int ERM_STEP_CYC      = ERM_STEP_US * CYC_PER_US;
  localparam int ERM_BASE_CYC      = ERM_BASE_US * CYC_PER_US;
  localparam int PERIOD_W          = 16;
  localparam logic [7:0] GAIN_NOMINAL = 8'h40;
  localparam logic [7:0] GAIN_BOOST   = 8'h60;
  localparam logic [7:0] GAIN_REDUCED = 8'h20;
  localparam logic [7:0] HALF_SCALE   = 8'h80;

  // Amplitude result handed to the output stage.
  typedef struct packed {
    logic             brake;
    logic [AMP_W-1:0] level;
  } drive_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DRIVE = 2'b01,
    ST_BRAKE = 2'b10
  } loop_state_t;
endpackage
`default_nettype wire

// *** core/drive_period_timer.sv ***
`default_nettype none
module drive_period_timer
  import haptic_loop_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  input  wire logic                run_i,
  input  wire logic [PERIOD_W-1:0] period_i,
  output logic                     tick_o
);
  logic [PERIOD_W-1:0] cnt_r;
  logic [PERIOD_W-1:0] cnt_nxt;

  // Counts down the period; restarts idle so a new period applies at once.
  always_comb begin
    tick_o  = run_i && (cnt_r == '0);
    cnt_nxt = cnt_r - 16'h0001;
    if (!run_i || tick_o) begin
      cnt_nxt = period_i - 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// *** core/amp_mapper.sv ***
`default_nettype none
module amp_mapper
  import haptic_loop_pkg::*;
(
  input  wire logic [AMP_W-1:0] amp_i,
  input  wire logic             signed_sel_i,
  output haptic_loop_pkg::drive_cmd_t cmd_o
);
  // Unidirectional uses the full code range; bidirectional centres on half.
  always_comb begin
    cmd_o.brake = 1'b0;
    cmd_o.level = amp_i;
    if (signed_sel_i) begin
      if (amp_i >= HALF_SCALE) begin
        cmd_o.level = 8'((amp_i - HALF_SCALE) << 1);
      end else begin
        cmd_o.brake = 1'b1;
        cmd_o.level = 8'((HALF_SCALE - amp_i) << 1);
      end
    end
  end
endmodule
`default_nettype wire

// *** core/haptic_loop_control_regs.sv ***
// What this block does
// R01: With the overdrive boost bit set, the loop gain is raised while overdriving.
// R02: The common-mode drive bit enables a 0.9 V bias on the input pin when 1.
// R03: Software sets common-mode drive only in analog input mode.
// R04: In LRA mode the initial drive time is field times 0.1 ms plus 0.5 ms.
// R05: In LRA mode that time is only a seed, then tracked toward the optimum.
// R06: Software programs the LRA seed to about half the resonant period.
// R07: In ERM mode back-EMF is sampled every field times 0.2 ms plus 1 ms; the 16-bit cycle count wraps for fields above 27.
// R08: The signed input bit selects unidirectional (0) or bidirectional (1) input.
// R09: Unidirectional mode brakes from feedback and uses the full range for drive.
// R10: Software selects unidirectional input only for closed-loop operation.
// R11: Unidirectional maps input linearly, 0% to none and 50% to half scale.
// R12: Bidirectional open loop treats 50% as zero, brakes below and drives above.
// R13: With the brake gain reduction bit set, gain drops as braking nears its end.
// R14: Reserved bit 6 of the first register reads zero and ignores writes.
`default_nettype none
module haptic_loop_control_regs
  import haptic_loop_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                lra_mode_i,
  input  wire logic                closed_loop_i,
  input  wire logic                play_i,
  input  wire logic [AMP_W-1:0]    amp_i,
  input  wire logic                overdrive_i,
  input  wire logic                brake_near_done_i,
  input  wire logic                lra_early_i,
  input  wire logic                lra_late_i,
  output logic                     cm_drive_en_o,
  output logic                     bemf_sample_o,
  output logic [PERIOD_W-1:0]      drive_period_o,
  output logic [7:0]               loop_gain_o,
  output haptic_loop_pkg::drive_cmd_t drive_cmd_o
);
  // ***************************************************************
  // Register bank and Wishbone slave.
  // ***************************************************************
  logic [7:0]          cfg1_r, cfg1_nxt;
  logic [7:0]          cfg2_r, cfg2_nxt;
  logic                ack_r, ack_nxt;
  logic [31:0]         rdat_r, rdat_nxt;
  logic [PERIOD_W-1:0] track_r, track_nxt;
  loop_state_t         state_r, state_nxt;
  logic [7:0]          gain_r, gain_nxt;
  drive_cmd_t          cmd_r, cmd_nxt;
  drive_cmd_t          map_cmd;
  logic                sample_tick;
  logic                lra_tick;
  logic [PERIOD_W-1:0] lra_seed;
  logic [PERIOD_W-1:0] erm_period;
  logic                acc;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  assign acc = wb_cyc_i && wb_stb_i && !ack_r;

  // Writes land at the edge where the master samples ack high, so the held request
  // is applied exactly once; read data is registered a cycle early to stand with ack.
  always_comb begin
    cfg1_nxt = cfg1_r;
    cfg2_nxt = cfg2_r;
    ack_nxt  = acc;
    rdat_nxt = rdat_r;
    if (wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0]) begin
      if (hit(wb_adr_i, REG_LOOP_DRIVE_CFG)) begin
        cfg1_nxt = wb_dat_i[7:0] & CFG1_WMASK; // R14
      end
      if (hit(wb_adr_i, REG_INPUT_TIMING_CFG)) begin
        cfg2_nxt = wb_dat_i[7:0];
      end
    end
    if (acc && !wb_we_i) begin
      rdat_nxt = 32'h0000_0000;
      if (hit(wb_adr_i, REG_LOOP_DRIVE_CFG)) begin
        rdat_nxt = {24'h00_0000, cfg1_r}; // R14
      end else if (hit(wb_adr_i, REG_INPUT_TIMING_CFG)) begin
        rdat_nxt = {24'h00_0000, cfg2_r};
      end else if (hit(wb_adr_i, REG_LOOP_STATUS)) begin
        rdat_nxt = {6'h00, state_r, 8'h00, track_r};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cfg1_r <= CFG1_RESET;
      cfg2_r <= CFG2_RESET;
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
      ack_r  <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ***************************************************************
  // Drive period seed, tracking and back-EMF sampling.
  // ***************************************************************
  // The seed is recomputed combinationally so a rewrite is seen on the next idle.
  assign lra_seed   = 16'(cfg1_r[DRIVE_W-1:0] * LRA_STEP_CYC + LRA_BASE_CYC); // R04
  assign erm_period = 16'(cfg1_r[DRIVE_W-1:0] * ERM_STEP_CYC + ERM_BASE_CYC); // R07
  assign cm_drive_en_o = cfg1_r[BIT_CM_DRIVE]; // R02

  // Tracking restarts from the seed whenever playback stops.
  always_comb begin
    track_nxt = track_r;
    if (!play_i || !lra_mode_i) begin
      track_nxt = lra_seed; // R04
    end else if (lra_tick && lra_early_i && track_r > 16'h0001) begin
      track_nxt = track_r - 16'h0001; // R05
    end else if (lra_tick && lra_late_i && track_r != 16'hffff) begin
      track_nxt = track_r + 16'h0001; // R05
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      track_r <= 16'(LRA_BASE_CYC);
    end else begin
      track_r <= track_nxt;
    end
  end

  drive_period_timer u_period (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .run_i    (play_i),
    .period_i (lra_mode_i ? track_r : erm_period),
    .tick_o   (sample_tick)
  );

  assign lra_tick       = sample_tick && lra_mode_i;
  assign bemf_sample_o  = sample_tick && !lra_mode_i; // R07
  assign drive_period_o = lra_mode_i ? track_r : erm_period;

  // ***************************************************************
  // Amplitude interpretation and loop gain.
  // ***************************************************************
  amp_mapper u_map (
    .amp_i        (amp_i),
    .signed_sel_i (cfg2_r[BIT_SIGNED_INPUT]), // R08
    .cmd_o        (map_cmd)
  );

  // Unidirectional braking comes from the feedback, not from the input code.
  always_comb begin
    cmd_nxt = map_cmd; // R11 R12
    if (!cfg2_r[BIT_SIGNED_INPUT]) begin
      cmd_nxt.brake = closed_loop_i && brake_near_done_i; // R09
    end
    if (!play_i) begin
      cmd_nxt = '0;
    end
  end

  // Gain follows the loop phase; boost and reduction are each software gated.
  always_comb begin
    state_nxt = ST_IDLE;
    gain_nxt  = GAIN_NOMINAL;
    if (play_i) begin
      state_nxt = cmd_nxt.brake ? ST_BRAKE : ST_DRIVE;
    end
    case (state_nxt)
      ST_DRIVE: begin
        if (overdrive_i && cfg1_r[BIT_OVERDRIVE_BOOST]) begin
          gain_nxt = GAIN_BOOST; // R01
        end
      end
      ST_BRAKE: begin
        if (brake_near_done_i && cfg2_r[BIT_BRAKE_GAIN_RED]) begin
          gain_nxt = GAIN_REDUCED; // R13
        end
      end
      default: begin
        gain_nxt = GAIN_NOMINAL;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_r <= ST_IDLE;
      gain_r  <= GAIN_NOMINAL;
      cmd_r   <= '0;
    end else begin
      state_r <= state_nxt;
      gain_r  <= gain_nxt;
      cmd_r   <= cmd_nxt;
    end
  end

  assign loop_gain_o = gain_r;
  assign drive_cmd_o = cmd_r;

  // ***************************************************************
  // Checks.
  // ***************************************************************
  sequence s_boost_cause;
    play_i && overdrive_i && cfg1_r[BIT_OVERDRIVE_BOOST] && !cmd_nxt.brake;
  endsequence
  property p_boost;
    @(posedge clk_i) disable iff (!nrst_i) s_boost_cause |=> loop_gain_o == GAIN_BOOST;
  endproperty
  a_boost: assert property (p_boost) else $error("boost gain missing"); // R01

  property p_cm;
    @(posedge clk_i) disable iff (!nrst_i) cm_drive_en_o == cfg1_r[BIT_CM_DRIVE];
  endproperty
  a_cm: assert property (p_cm) else $error("common mode drive mismatch"); // R02

  property p_seed;
    @(posedge clk_i) disable iff (!nrst_i)
      (lra_mode_i && !play_i)
        |=> track_r == 16'($past(cfg1_r[DRIVE_W-1:0]) * LRA_STEP_CYC + LRA_BASE_CYC);
  endproperty
  a_seed: assert property (p_seed) else $error("lra seed wrong"); // R04

  property p_track;
    @(posedge clk_i) disable iff (!nrst_i)
      (play_i && lra_mode_i && !lra_tick) ##1 (play_i && lra_mode_i) |-> $stable(track_r);
  endproperty
  a_track: assert property (p_track) else $error("tracking moved without tick"); // R05

  property p_erm;
    @(posedge clk_i) disable iff (!nrst_i)
      (!lra_mode_i && bemf_sample_o) ##1 (!lra_mode_i && play_i)[*8] |-> !bemf_sample_o;
  endproperty
  a_erm: assert property (p_erm) else $error("bemf sample too soon"); // R07

  property p_bidir;
    @(posedge clk_i) disable iff (!nrst_i)
      (play_i && cfg2_r[BIT_SIGNED_INPUT] && amp_i == HALF_SCALE) |=> drive_cmd_o.level == 8'h00;
  endproperty
  a_bidir: assert property (p_bidir) else $error("mid input not zero"); // R12

  property p_unidir;
    @(posedge clk_i) disable iff (!nrst_i)
      (play_i && !cfg2_r[BIT_SIGNED_INPUT]) |=> drive_cmd_o.level == $past(amp_i);
  endproperty
  a_unidir: assert property (p_unidir) else $error("unidirectional not linear"); // R11

  property p_brake_red;
    @(posedge clk_i) disable iff (!nrst_i)
      (play_i && cmd_nxt.brake && brake_near_done_i && cfg2_r[BIT_BRAKE_GAIN_RED])
        |=> loop_gain_o == GAIN_REDUCED;
  endproperty
  a_brake_red: assert property (p_brake_red) else $error("brake gain not reduced"); // R13

  property p_rsvd;
    @(posedge clk_i) disable iff (!nrst_i) cfg1_r[BIT_RESERVED_CFG1] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set"); // R14
endmodule
`default_nettype wire

// *** bench/haptic_loop_control_regs_bench.sv ***
`default_nettype none
module haptic_loop_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import haptic_loop_pkg::*;

  // ***************************************************************
  // Stimulus and observation signals.
  // ***************************************************************
  logic                clk_i;
  logic                nrst_i;
  logic                cyc, stb, we, ack;
  logic [7:0]          adr;
  logic [3:0]          sel;
  logic [31:0]         wdat, dat_o, rd;
  logic                lra_mode, closed_loop, play, overdrive, brake_near, early, late;
  logic [AMP_W-1:0]    amp;
  logic                cm_en, bemf;
  logic [PERIOD_W-1:0] period;
  logic [7:0]          gain;
  drive_cmd_t          cmd;
  int                  errors, n_compared, cycles, n;

  haptic_loop_control_regs dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .lra_mode_i(lra_mode), .closed_loop_i(closed_loop), .play_i(play), .amp_i(amp),
    .overdrive_i(overdrive), .brake_near_done_i(brake_near), .lra_early_i(early),
    .lra_late_i(late), .cm_drive_en_o(cm_en), .bemf_sample_o(bemf),
    .drive_period_o(period), .loop_gain_o(gain), .drive_cmd_o(cmd));

  // A free-running 10 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // The ceiling sits well above the two long period measurements.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors = errors + 1;
      results();
    end
  end

  // ***************************************************************
  // Bus cycles, comparisons and the closing report.
  // ***************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The request is held until ack is sampled high; a hang is left to the timeout.
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [7:0] d,
                          input logic [3:0] s);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb_cycle(1'b1, a, d, 4'h1);
  endtask

  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb_cycle(1'b0, a, 8'h00, 4'hf);
    check(what, exp, rd);
  endtask

  // Settles the registered outputs before they are compared.
  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask

  task automatic amp_case(input logic [7:0] a, input logic [8:0] exp);
    @(posedge clk_i);
    amp <= a;
    settle();
    check("drive_cmd", {23'h0, exp}, {23'h0, cmd});
  endtask

  task automatic wait_bemf();
    do @(posedge clk_i); while (bemf !== 1'b1);
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ***************************************************************
  // Test sequence.
  // ***************************************************************
  initial begin
    {nrst_i, cyc, stb, we, lra_mode, closed_loop, play, overdrive} = 8'h00;
    {brake_near, early, late} = 3'b000;
    adr = 8'h00; sel = 4'h0; wdat = 32'h0; amp = 8'h80;
    errors = 0; n_compared = 0; cycles = 0; n = 0;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd_check("cfg1 reset", REG_LOOP_DRIVE_CFG, 32'h93);
    rd_check("cfg2 reset", REG_INPUT_TIMING_CFG, 32'hf5);
    check("gain reset", 32'h40, {24'h0, gain});
    $display("test reset done");
    wr(REG_LOOP_DRIVE_CFG, 8'hff);
    rd_check("cfg1 reserved", REG_LOOP_DRIVE_CFG, 32'hbf);
    check("cm drive on", 32'h1, {31'h0, cm_en});
    wr(REG_LOOP_DRIVE_CFG, 8'h93);
    check("cm drive off", 32'h0, {31'h0, cm_en});
    wb_cycle(1'b1, REG_LOOP_DRIVE_CFG, 8'h00, 4'h0);
    rd_check("cfg1 sel off", REG_LOOP_DRIVE_CFG, 32'h93);
    rd_check("unmapped", 8'h20, 32'h0);
    $display("test access done");
    // Gain follows the loop phase and the two gain bits.
    overdrive <= 1'b1;
    play      <= 1'b1;
    settle();
    check("gain boost", 32'h60, {24'h0, gain});
    wr(REG_LOOP_DRIVE_CFG, 8'h13);
    settle();
    check("gain no boost", 32'h40, {24'h0, gain});
    overdrive  <= 1'b0;
    brake_near <= 1'b1;
    amp        <= 8'h40;
    settle();
    check("gain reduced", 32'h20, {24'h0, gain});
    wr(REG_INPUT_TIMING_CFG, 8'hb5);
    settle();
    check("gain no reduce", 32'h40, {24'h0, gain});
    brake_near <= 1'b0;
    $display("test gain done");
    // Bidirectional mapping: 50% is zero, below brakes, above drives.
    wr(REG_INPUT_TIMING_CFG, 8'hf5);
    play <= 1'b1;
    amp_case(8'h80, 9'h000);
    amp_case(8'h40, 9'h180);
    amp_case(8'hc0, 9'h080);
    // Unidirectional mapping is linear; braking comes from feedback.
    wr(REG_INPUT_TIMING_CFG, 8'h75);
    closed_loop <= 1'b1;
    amp_case(8'h00, 9'h000);
    amp_case(8'h80, 9'h080);
    amp_case(8'hfe, 9'h0fe);
    brake_near <= 1'b1;
    amp_case(8'h80, 9'h180);
    brake_near <= 1'b0;
    play <= 1'b0;
    $display("test mapping done");
    // ERM sample period: figure for field 19, then the measured pulse spacing.
    wr(REG_LOOP_DRIVE_CFG, 8'h93);
    settle();
    check("erm period", 32'd48000, {16'h0, period});
    wr(REG_LOOP_DRIVE_CFG, 8'h80);
    play <= 1'b1;
    wait_bemf();
    wait_bemf();
    n = 0;
    do begin
      @(posedge clk_i);
      n = n + 1;
    end while (bemf !== 1'b1);
    check("bemf spacing", 32'd10000, n);
    play <= 1'b0;
    $display("test erm done");
    // LRA seed, then tracking away from it while playing.
    lra_mode <= 1'b1;
    wr(REG_LOOP_DRIVE_CFG, 8'h93);
    settle();
    check("lra seed 13", 32'd24000, {16'h0, period});
    wr(REG_LOOP_DRIVE_CFG, 8'h80);
    settle();
    check("lra seed 0", 32'd5000, {16'h0, period});
    late <= 1'b1;
    play <= 1'b1;
    repeat (12000) @(posedge clk_i);
    check("lra tracked", 32'h1, {31'h0, period !== 16'd5000});
    $display("test lra done");
    results();
  end
endmodule
`default_nettype wire
